// >>> rxc_pkg.sv
/*
 * Shared constants for the receiver calibration and trim register bank:
 * serial framing, register address codes, field positions, reset values.
 * Assumes both serial ends include this package; one 25 MHz system clock.
 */
package rxc_pkg;
    localparam int WORD_BITS = 32;
    localparam logic [2:0] ADDR_CAL = 3'h2;
    localparam logic [2:0] ADDR_MIX = 3'h3;
    localparam logic [2:0] ADDR_REG4 = 3'h4;
    localparam logic [2:0] ADDR_BIAS = 3'h5;
    // Calibration register fields
    localparam int CAL_START_BIT = 5;
    localparam int IDAC_LSB = 6;
    localparam int QDAC_LSB = 14;
    localparam int IDET_LSB = 22;
    localparam int CAL_SEL_BIT = 24;
    localparam int DIV_LSB = 25;
    localparam int CLK_SEL_BIT = 28;
    localparam int TRIM_LSB = 29;
    localparam logic [7:0] IDAC_RST = 8'h80;
    localparam logic [7:0] QDAC_RST = 8'h80;
    localparam logic [1:0] IDET_RST = 2'h3;
    localparam logic CAL_SEL_RST = 1'b1;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic CLK_SEL_RST = 1'b1;
    localparam logic [2:0] TRIM_RST = 3'h1;
    // Mixer-load register fields
    localparam int LOAD_LSB = 5;
    localparam int LOAD_BITS = 24;
    localparam int BYPASS_BIT = 29;
    localparam int PEAK_LSB = 30;
    localparam logic [1:0] PEAK_RST = 2'h1;
    localparam logic [1:0] PEAK_BYPASS = 2'h0;
    // Bias register fields
    localparam int BIAS_LSB = 5;
    localparam int BIAS_FIELDS = 6;
    localparam logic [1:0] BIAS_RST = 2'h1;
    // Serial half period
    localparam int SER_HALF_NS = 160;
    localparam int CLK_NS = 40;
    localparam int SER_HALF_CYC = (SER_HALF_NS / CLK_NS < 1) ? 1 : SER_HALF_NS / CLK_NS;
    // Divider ratios; last one is 16384, so the ratio values need 15 bits
    localparam int DIV_W = 15;
    localparam logic [14:0] RATIO_0 = 15'h0001;
    localparam logic [14:0] RATIO_1 = 15'h0008;
    localparam logic [14:0] RATIO_2 = 15'h0010;
    localparam logic [14:0] RATIO_3 = 15'h0080;
    localparam logic [14:0] RATIO_4 = 15'h0100;
    localparam logic [14:0] RATIO_5 = 15'h0400;
    localparam logic [14:0] RATIO_6 = 15'h0800;
    localparam logic [14:0] RATIO_7 = 15'h4000;
    typedef enum logic [2:0] {
        RXC_IDLE = 3'b001,
        RXC_SHIFT = 3'b010,
        RXC_LATCH = 3'b100
    } rxc_hst_t;
endpackage

// >>> rxc_if.sv
/*
 * Three-wire serial link between host controller and receiver bank.
 * Assumes the host alone drives all three wires.
 */
`timescale 1ns/1ps
interface rxc_if;
    logic ser_clk;
    logic ser_data;
    logic ser_le;
    modport host (output ser_clk, output ser_data, output ser_le);
    modport dev (input ser_clk, input ser_data, input ser_le);
endinterface

// >>> rxc_dev.sv
/*
 * Receiver end: shifts in 32-bit words, latches them into the calibration,
 * mixer-load and bias registers, and divides the calibration clock.
 * Assumes serial pins and oscillator are asynchronous to clk_i.
 */
`timescale 1ns/1ps
module rxc_dev (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Serial link
    rxc_if.dev ser,
    // Analog side
    input wire logic osc_clk_i,
    input wire logic cal_done_i,
    // Calibration controls
    output logic [7:0] inphase_offset_dac_value_o,
    output logic [7:0] quadrature_offset_dac_value_o,
    output logic [1:0] detector_reference_current_o,
    output logic cal_auto_o,
    output logic autocal_run_o,
    output logic [2:0] osc_trim_o,
    output logic cal_tick_o,
    // Mixer and filter
    output logic [5:0] inphase_mixer_load_side_a_o,
    output logic [5:0] inphase_mixer_load_side_b_o,
    output logic [5:0] quadrature_mixer_load_side_a_o,
    output logic [5:0] quadrature_mixer_load_side_b_o,
    output logic filter_bypass_o,
    output logic [1:0] peaking_adjust_o,
    // Bias trims
    output logic [1:0] mixer_transconductance_bias_o,
    output logic [1:0] mixer_switch_common_mode_bias_o,
    output logic [1:0] local_osc_buffer_bias_o,
    output logic [1:0] mixer_output_buffer_bias_o,
    output logic [1:0] filter_bias_o,
    output logic [1:0] filter_output_buffer_bias_o
);
    import rxc_pkg::*;

    typedef struct packed {
        logic [1:0] clk_s;
        logic [1:0] dat_s;
        logic [1:0] le_s;
        logic [1:0] osc_s;
        logic clk_q;
        logic le_q;
        logic osc_q;
        logic [31:0] shift;
        logic [31:0] cal;
        logic [31:0] mix;
        logic [31:0] bias;
        logic [DIV_W-1:0] div_cnt;
        logic tick;
    } rxc_dev_st_t;

    rxc_dev_st_t st_ff;
    rxc_dev_st_t nxt_st;

    localparam logic [31:0] CAL_RST = {TRIM_RST, CLK_SEL_RST, DIV_RST, CAL_SEL_RST,
                                       IDET_RST, QDAC_RST, IDAC_RST, 6'h00};
    localparam logic [31:0] MIX_RST = {PEAK_RST, 30'h00000000};
    localparam logic [31:0] BIAS_RST_W = {15'h0000, {BIAS_FIELDS{BIAS_RST}}, 5'h00};

    function automatic logic [DIV_W-1:0] ratio_of(input logic [2:0] code);
        case (code)
            3'h0: ratio_of = RATIO_0;
            3'h1: ratio_of = RATIO_1;
            3'h2: ratio_of = RATIO_2;
            3'h3: ratio_of = RATIO_3;
            3'h4: ratio_of = RATIO_4;
            3'h5: ratio_of = RATIO_5;
            3'h6: ratio_of = RATIO_6;
            default: ratio_of = RATIO_7;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic clk_rise;
    logic le_rise;
    logic osc_rise;
    logic src_edge;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.clk_s = {st_ff.clk_s[0], ser.ser_clk};
        nxt_st.dat_s = {st_ff.dat_s[0], ser.ser_data};
        nxt_st.le_s = {st_ff.le_s[0], ser.ser_le};
        nxt_st.osc_s = {st_ff.osc_s[0], osc_clk_i};
        nxt_st.clk_q = st_ff.clk_s[1];
        nxt_st.le_q = st_ff.le_s[1];
        nxt_st.osc_q = st_ff.osc_s[1];
        clk_rise = st_ff.clk_s[1] & ~st_ff.clk_q;
        le_rise = st_ff.le_s[1] & ~st_ff.le_q;
        osc_rise = st_ff.osc_s[1] & ~st_ff.osc_q;
        // First bit sent ends up in bit 0
        if (clk_rise) begin
            nxt_st.shift = {st_ff.dat_s[1], st_ff.shift[31:1]};
        end
        // Done clears start; a write in the same cycle wins below
        if (cal_done_i) begin
            nxt_st.cal[CAL_START_BIT] = 1'b0;
        end
        if (le_rise) begin
            case (st_ff.shift[2:0])
                ADDR_CAL: nxt_st.cal = st_ff.shift;
                ADDR_MIX: nxt_st.mix = st_ff.shift;
                ADDR_BIAS: nxt_st.bias = st_ff.shift;
                default: ;
            endcase
        end
        // Calibration clock source and divider
        src_edge = st_ff.cal[CLK_SEL_BIT] ? osc_rise : clk_rise;
        nxt_st.tick = 1'b0;
        if (src_edge) begin
            if (st_ff.div_cnt >= ratio_of(st_ff.cal[DIV_LSB +: 3]) - 15'h0001) begin
                nxt_st.div_cnt = 15'h0000;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.div_cnt = st_ff.div_cnt + 15'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= '0;
            st_ff.cal <= CAL_RST;
            st_ff.mix <= MIX_RST;
            st_ff.bias <= BIAS_RST_W;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign inphase_offset_dac_value_o = st_ff.cal[IDAC_LSB +: 8];
    assign quadrature_offset_dac_value_o = st_ff.cal[QDAC_LSB +: 8];
    assign detector_reference_current_o = st_ff.cal[IDET_LSB +: 2];
    assign cal_auto_o = st_ff.cal[CAL_SEL_BIT];
    // Start only matters when automatic method is chosen
    assign autocal_run_o = st_ff.cal[CAL_START_BIT] & st_ff.cal[CAL_SEL_BIT];
    assign osc_trim_o = st_ff.cal[TRIM_LSB +: 3];
    assign cal_tick_o = st_ff.tick;
    assign inphase_mixer_load_side_a_o = st_ff.mix[LOAD_LSB +: 6];
    assign inphase_mixer_load_side_b_o = st_ff.mix[LOAD_LSB + 6 +: 6];
    assign quadrature_mixer_load_side_a_o = st_ff.mix[LOAD_LSB + 12 +: 6];
    assign quadrature_mixer_load_side_b_o = st_ff.mix[LOAD_LSB + 18 +: 6];
    assign filter_bypass_o = st_ff.mix[BYPASS_BIT];
    assign peaking_adjust_o = st_ff.mix[PEAK_LSB +: 2];
    assign mixer_transconductance_bias_o = st_ff.bias[BIAS_LSB +: 2];
    assign mixer_switch_common_mode_bias_o = st_ff.bias[BIAS_LSB + 2 +: 2];
    assign local_osc_buffer_bias_o = st_ff.bias[BIAS_LSB + 4 +: 2];
    assign mixer_output_buffer_bias_o = st_ff.bias[BIAS_LSB + 6 +: 2];
    assign filter_bias_o = st_ff.bias[BIAS_LSB + 8 +: 2];
    assign filter_output_buffer_bias_o = st_ff.bias[BIAS_LSB + 10 +: 2];
endmodule

// >>> rxc_host.sv
/*
 * Host end: takes 32-bit words from the user and sends them LSB first
 * over the three-wire link, then pulses latch enable.
 * Assumes the user holds the word only for the accepting cycle.
 */
`timescale 1ns/1ps
module rxc_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // User write port
    input wire logic wr_valid_i,
    input wire logic [31:0] wr_data_i,
    output logic wr_ready_o,
    // Serial link
    rxc_if.host ser
);
    import rxc_pkg::*;

    typedef struct packed {
        rxc_hst_t state;
        logic [31:0] word;
        logic [4:0] bit_cnt;
        logic [7:0] half_cnt;
        logic sclk;
        logic sdat;
        logic sle;
    } rxc_host_st_t;

    rxc_host_st_t st_ff;
    rxc_host_st_t nxt_st;
    logic half_tick;
    logic [31:0] fixed;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        fixed = wr_data_i;
        // Keep mixer-load word legal whatever the user supplies
        if (wr_data_i[2:0] == ADDR_MIX) begin
            fixed[LOAD_LSB +: LOAD_BITS] = '0;
            fixed[PEAK_LSB +: 2] = wr_data_i[BYPASS_BIT] ? PEAK_BYPASS : PEAK_RST;
        end
        half_tick = (st_ff.half_cnt == 8'(SER_HALF_CYC - 1));
        nxt_st.half_cnt = half_tick ? 8'h00 : st_ff.half_cnt + 8'h01;
        case (st_ff.state)
            RXC_IDLE: begin
                nxt_st.half_cnt = 8'h00;
                // Register four is never needed, so no special path
                if (wr_valid_i) begin
                    nxt_st.word = fixed;
                    nxt_st.sdat = fixed[0];
                    nxt_st.bit_cnt = 5'h00;
                    nxt_st.state = RXC_SHIFT;
                end
            end
            RXC_SHIFT: begin
                if (half_tick) begin
                    nxt_st.sclk = ~st_ff.sclk;
                    // Data moves on the falling edge, stable at the rise
                    if (st_ff.sclk) begin
                        if (st_ff.bit_cnt == 5'h1f) begin
                            nxt_st.sdat = 1'b0;
                            nxt_st.sle = 1'b1;
                            nxt_st.state = RXC_LATCH;
                        end else begin
                            nxt_st.word = {1'b0, st_ff.word[31:1]};
                            nxt_st.sdat = st_ff.word[1];
                            nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
                        end
                    end
                end
            end
            RXC_LATCH: begin
                if (half_tick) begin
                    nxt_st.sle = 1'b0;
                    nxt_st.state = RXC_IDLE;
                end
            end
            default: begin
                nxt_st.state = RXC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= '0;
            st_ff.state <= RXC_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign wr_ready_o = (st_ff.state == RXC_IDLE);
    assign ser.ser_clk = st_ff.sclk;
    assign ser.ser_data = st_ff.sdat;
    assign ser.ser_le = st_ff.sle;
endmodule

// >>> rxc_monitor.sv
/* Checker for the serial link and the user ports of both ends.
   Assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/1ps
module rxc_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Link and user side
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_le,
    input wire logic wr_valid_i,
    input wire logic wr_ready_o,
    input wire logic cal_done_i,
    input wire logic autocal_run_o,
    input wire logic cal_auto_o,
    input wire logic cal_tick_o,
    input wire logic filter_bypass_o,
    input wire logic [1:0] peaking_adjust_o
);
    logic [5:0] rise_ff;
    logic clk_q_ff;
    // Serial clock rises since the last accepted word
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rise_ff <= 6'h0;
            clk_q_ff <= 1'b0;
        end else begin
            clk_q_ff <= ser_clk;
            if (wr_valid_i && wr_ready_o)
                rise_ff <= 6'h0;
            else if (ser_clk && !clk_q_ff)
                rise_ff <= rise_ff + 6'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_take;
        wr_valid_i && wr_ready_o;
    endsequence
    sequence s_le_pulse;
        ser_le [*4] ##1 !ser_le;
    endsequence
    a_frame_bit_count: assert property ($rose(ser_le) |-> rise_ff == 6'h20)
        else $error("latch enable after wrong bit count");
    a_latch_pulse_shape: assert property ($rose(ser_le) |-> !ser_clk ##0 s_le_pulse)
        else $error("latch enable pulse malformed");
    a_clk_half_period: assert property ($rose(ser_clk) |-> ser_clk [*4] ##1 !ser_clk)
        else $error("serial clock high phase wrong");
    a_idle_wires_low: assert property (wr_ready_o |-> !ser_clk && !ser_le)
        else $error("link active while host idle");
    a_take_drops_ready: assert property (s_take |=> !wr_ready_o)
        else $error("ready stayed high after accept");
    a_frame_length: assert property (s_take |-> ##[258:262] $rose(wr_ready_o))
        else $error("frame length wrong");
    a_tick_one_cycle: assert property (cal_tick_o |=> !cal_tick_o)
        else $error("calibration tick longer than a cycle");
    a_done_clears_run: assert property (cal_done_i && wr_ready_o && $past(wr_ready_o, 2)
        |=> !autocal_run_o)
        else $error("autocal not cleared by done");
    a_run_needs_auto: assert property (autocal_run_o |-> cal_auto_o)
        else $error("autocal running in manual mode");
    a_peak_follows: assert property (peaking_adjust_o == (filter_bypass_o ? 2'h0 : 2'h1))
        else $error("peaking field does not follow bypass");
    a_data_low_latch: assert property (ser_le |-> !ser_data)
        else $error("serial data high during latch enable");
    a_run_only_written: assert property ($rose(autocal_run_o) |-> ser_le)
        else $error("autocal started without a latched write");
endmodule

// >>> rxc_tb.sv
/* Bench joining host and device over the link, with a word-level model.
   Assumes the package address codes and a 25 MHz clock. */
`timescale 1ns/1ps
module rxc_tb;
    import rxc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wr_valid_i = 1'b0;
    logic [31:0] wr_data_i = 32'h0;
    logic osc_clk_i = 1'b0;
    logic cal_done_i = 1'b0;
    logic wr_ready_o, cauto, run, tick, byp;
    logic [7:0] idac, qdac;
    logic [5:0] ila, ilb, qla, qlb;
    logic [2:0] trim;
    logic [1:0] idet, peak, gm, sw, lo, mb, flt, ob;
    logic [1:0] oc = 2'h0;
    logic [31:0] m_cal, m_mix, m_bias, w;
    logic [2:0] amap [8] = '{3'h2, 3'h3, 3'h5, 3'h0, 3'h4, 3'h7, 3'h1, 3'h6};
    int ratio [5] = '{1, 8, 16, 128, 256};
    int failures = 0;
    int n_tests = 0;
    int tick_cnt = 0;
    int seed = 83873;
    wire logic [31:0] g_cal = {trim, 4'h0, cauto, idet, qdac, idac, run, 5'h0};
    wire logic [31:0] e_cal = {m_cal[31:29], 4'h0, m_cal[24:6], m_cal[5] & m_cal[24], 5'h0};
    wire logic [31:0] g_mix = {peak, byp, qlb, qla, ilb, ila, 5'h0};
    wire logic [31:0] g_bias = {15'h0, ob, flt, mb, lo, sw, gm, 5'h0};
    rxc_if lnk();
    rxc_host u_rxc_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .wr_valid_i(wr_valid_i),
        .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o), .ser(lnk));
    rxc_dev u_rxc_dev (.clk_i(clk_i), .rst_b_i(rst_b_i), .ser(lnk), .osc_clk_i(osc_clk_i),
        .cal_done_i(cal_done_i), .inphase_offset_dac_value_o(idac),
        .quadrature_offset_dac_value_o(qdac), .detector_reference_current_o(idet),
        .cal_auto_o(cauto), .autocal_run_o(run), .osc_trim_o(trim), .cal_tick_o(tick),
        .inphase_mixer_load_side_a_o(ila), .inphase_mixer_load_side_b_o(ilb),
        .quadrature_mixer_load_side_a_o(qla), .quadrature_mixer_load_side_b_o(qlb),
        .filter_bypass_o(byp), .peaking_adjust_o(peak), .mixer_transconductance_bias_o(gm),
        .mixer_switch_common_mode_bias_o(sw), .local_osc_buffer_bias_o(lo),
        .mixer_output_buffer_bias_o(mb), .filter_bias_o(flt), .filter_output_buffer_bias_o(ob));
    rxc_monitor u_rxc_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i), .ser_clk(lnk.ser_clk),
        .ser_data(lnk.ser_data), .ser_le(lnk.ser_le), .wr_valid_i(wr_valid_i),
        .wr_ready_o(wr_ready_o), .cal_done_i(cal_done_i), .autocal_run_o(run),
        .cal_auto_o(cauto), .cal_tick_o(tick), .filter_bypass_o(byp), .peaking_adjust_o(peak));
    always #20 clk_i = ~clk_i;
    // Oscillator period of six cycles, slow enough for the synchroniser
    always @(posedge clk_i) begin
        oc <= (oc === 2'h2) ? 2'h0 : oc + 2'h1;
        if (oc === 2'h2) osc_clk_i <= ~osc_clk_i;
    end
    always @(negedge clk_i) if (tick === 1'b1) tick_cnt++;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_count(input int got, input int exp);
        cmp_word(got, exp);
    endtask
    task automatic chk;
        @(negedge clk_i);
        cmp_word(g_cal, e_cal);
        cmp_word(g_mix, {m_mix[31:5], 5'h0});
        cmp_word(g_bias, {15'h0, m_bias[16:5], 5'h0});
    endtask
    task automatic do_reset;
        rst_b_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        m_cal = 32'h31e0_2000;
        m_mix = 32'h4000_0000;
        m_bias = 32'h0000_aaa0;
    endtask
    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (wr_ready_o !== 1'b1 && k < 400);
    endtask
    task automatic wr(input logic [31:0] v);
        wait_ready();
        @(posedge clk_i);
        wr_valid_i <= 1'b1;
        wr_data_i <= v;
        @(posedge clk_i);
        wr_valid_i <= 1'b0;
        wait_ready();
        repeat (8) @(posedge clk_i);
        // Host clears the load fields and sets peaking from bypass
        case (v[2:0])
            ADDR_CAL: m_cal = v;
            ADDR_MIX: m_mix = {v[29] ? 2'h0 : 2'h1, v[29], 29'h0};
            ADDR_BIAS: m_bias = v;
            default: ;
        endcase
        chk();
    endtask
    task automatic meas(input int exp);
        int k, n;
        logic p;
        k = 0;
        n = 0;
        while (tick !== 1'b1 && k < 4000) begin
            @(negedge clk_i);
            k++;
        end
        p = osc_clk_i;
        do begin
            @(negedge clk_i);
            n += (osc_clk_i && !p) ? 1 : 0;
            p = osc_clk_i;
            k++;
        end while (tick !== 1'b1 && k < 4000);
        cmp_count(n, exp);
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk_i);
        failures++;
        final_report();
    end
    initial begin
        do_reset();
        chk();
        // Ratios rise only, so the divider count never has to wrap
        for (int c = 0; c < 5; c++) begin
            if (c == 1) begin
                w = {3'h6, 1'b0, 3'h1, 1'b0, 2'h1, 8'h01, 8'hfe, 1'b1, 5'h02};
                wr(w);
                tick_cnt = 0;
                wr(w);
                cmp_count(tick_cnt, 32 / 8);
            end
            wr({3'h6, 1'b1, c[2:0], 1'b1, 2'h0, 8'h55, 8'haa, 1'b0, 5'h02});
            meas(ratio[c]);
        end
        wr({3'h6, 1'b1, 3'h0, 1'b1, 2'h2, 8'h33, 8'hcc, 1'b1, 5'h02});
        @(posedge clk_i);
        cal_done_i <= 1'b1;
        @(posedge clk_i);
        cal_done_i <= 1'b0;
        m_cal[5] = 1'b0;
        chk();
        @(posedge clk_i);
        wr_valid_i <= 1'b1;
        wr_data_i <= 32'h0000_5555;
        @(posedge clk_i);
        wr_valid_i <= 1'b0;
        repeat (100) @(posedge clk_i);
        do_reset();
        chk();
        for (int i = 0; i < 16; i++) begin
            w = $random(seed);
            w[2:0] = amap[i % 8];
            wr(w);
        end
        final_report();
    end
endmodule
